// file: design/afg_firing_gen.sv
`timescale 1ns/1ns
`default_nettype none

module afg_firing_gen #(
  parameter int PCT_TICK = afg_pkg::PCT_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [afg_pkg::AW-1:0] reg_addr,
  input wire logic [afg_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [afg_pkg::DW-1:0] reg_rdata,
  input wire logic zero_cross,
  input wire logic line_pos,
  input wire logic enable_in,
  input wire logic [11:0] ain_1,
  output logic gate_out
);
  import afg_pkg::*;

  // Every check here runs on the system clock and rests while reset is held.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  afg_mode_t mode;
  logic src_op;
  logic [7:0] min_cycles;
  logic [7:0] delay_deg;
  logic [7:0] ramp_steps;
  logic [7:0] ain_gain;
  logic [6:0] op_sp;

  logic en_q;
  logic [6:0] eff_sp;
  logic [23:0] tick_cnt;

  logic [19:0] timer;
  logic [19:0] period;
  logic valid;
  logic hc_pos;

  logic [8:0] acc_h;
  logic half_on;
  logic last_pol;

  logic [15:0] acc_b;
  logic [7:0] burst_left;
  logic [7:0] off_cnt;
  logic burst_on;
  logic burst_first;

  logic next_gate;

  // Register write decode.
  wire logic wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
  wire logic wr_min = reg_wr && (reg_addr == OFF_MIN_CYC);
  wire logic wr_delay = reg_wr && (reg_addr == OFF_DELAY);
  wire logic wr_ramp = reg_wr && (reg_addr == OFF_RAMP);
  wire logic wr_sp = reg_wr && (reg_addr == OFF_SETPOINT);
  wire logic wr_gain = reg_wr && (reg_addr == OFF_AIN_GAIN);

  // Written values are clamped so the datapath never sees an impossible
  // demand, angle or a zero-length burst.
  wire logic [7:0] wr_byte = reg_wdata[7:0];
  wire logic [6:0] wr_pct = (wr_byte > {1'b0, PCT_FULL}) ? PCT_FULL :
                            wr_byte[6:0];
  wire logic [7:0] wr_deg = (wr_byte > DEG_MAX) ? DEG_MAX : wr_byte;
  wire logic [7:0] wr_cyc = (wr_byte == 8'h00) ? RST_MIN_CYC : wr_byte;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= RST_MODE;
      src_op <= RST_SRC;
      min_cycles <= RST_MIN_CYC;
      delay_deg <= RST_DELAY;
      ramp_steps <= RST_RAMP;
      op_sp <= RST_SETPOINT;
      ain_gain <= RST_AIN_GAIN;
    end else begin
      if (wr_ctrl) begin
        mode <= afg_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
        src_op <= reg_wdata[CTRL_SRC_BIT];
      end
      if (wr_min) begin
        min_cycles <= wr_cyc;
      end
      if (wr_delay) begin
        delay_deg <= wr_deg;
      end
      if (wr_ramp) begin
        ramp_steps <= wr_byte;
      end
      if (wr_sp) begin
        op_sp <= wr_pct;
      end
      if (wr_gain) begin
        ain_gain <= wr_byte;
      end
    end
  end

  // Analog set point: gain of 100 maps full scale to 100 percent.
  wire logic [19:0] ain_prod = ain_1 * ain_gain;
  wire logic [7:0] ain_pct = ain_prod[19:12];
  wire logic [6:0] ain_sp = (ain_pct > {1'b0, PCT_FULL}) ? PCT_FULL :
                            ain_pct[6:0];
  wire logic [6:0] set_sp = src_op ? op_sp : ain_sp;
  wire logic [6:0] target = enable_in ? set_sp : 7'h00;

  // Soft-start filter: one percent per tick, so a full swing takes the
  // programmed number of 50 ms steps.
  wire logic en_fall = en_q && !enable_in;
  wire logic ramp_off = (mode == AFG_PHASE) || (ramp_steps == 8'h00);
  wire logic [23:0] tick_load = 24'(ramp_steps * PCT_TICK - 1);
  wire logic tick = (tick_cnt == 24'h000000);
  wire logic [6:0] step_sp = (eff_sp < target) ? eff_sp + 7'h01 :
                             (eff_sp > target) ? eff_sp - 7'h01 : eff_sp;
  wire logic [6:0] next_eff =
    (mode == AFG_PHASE_RAMP && en_fall) ? 7'h00 :
    ramp_off ? target :
    tick ? step_sp : eff_sp;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      eff_sp <= 7'h00;
      tick_cnt <= 24'h000000;
    end else begin
      en_q <= enable_in;
      eff_sp <= next_eff;
      tick_cnt <= (tick || eff_sp == target) ? tick_load : tick_cnt - 24'h1;
    end
  end

  // Line timing: the half-cycle period is measured between zero crosses.
  // A saturated timer means the line is missing and angles are not fired.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer <= 20'h00000;
      period <= 20'h00000;
      valid <= 1'b0;
      hc_pos <= 1'b0;
    end else if (zero_cross) begin
      timer <= 20'h00000;
      period <= (timer == TIMER_MAX) ? TIMER_MAX : timer + 20'h1;
      valid <= (timer != TIMER_MAX);
      hc_pos <= line_pos;
    end else if (timer != TIMER_MAX) begin
      timer <= timer + 20'h1;
    end else begin
      valid <= 1'b0;
    end
  end

  // Phase angle from demand: 180 * (100 - p) / 100.
  wire logic [6:0] off_pct = PCT_FULL - eff_sp;
  wire logic [15:0] pd_prod = off_pct * PCT_TO_DEG;
  wire logic [7:0] phase_deg = pd_prod[15:8];
  wire logic [7:0] fire_deg = (mode == AFG_BURST_DELAY) ? delay_deg :
                              phase_deg;
  wire logic [16:0] deg_k = fire_deg * RECIP_180;
  wire logic [36:0] thr_prod = period * deg_k;
  wire logic [19:0] thr = thr_prod[35:16];
  wire logic fire_now = valid && (timer >= thr);
  wire logic full = (eff_sp == PCT_FULL);

  // Half cycle: credit accrues p per half against a modulus of p + 50 below
  // half demand and 100 above it, which gives the one-in-three pattern at
  // 25 percent. Firing is held back while the polarity would repeat.
  wire logic [7:0] h_mod = (eff_sp < PCT_HALF) ?
                           {1'b0, eff_sp} + {1'b0, PCT_HALF} :
                           {1'b0, PCT_FULL};
  wire logic [8:0] h_sum = acc_h + {2'b00, eff_sp};
  wire logic h_credit = (eff_sp != 7'h00) && (h_sum >= {1'b0, h_mod});
  wire logic h_conduct = full || (h_credit && (line_pos != last_pol));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_h <= 9'h000;
      half_on <= 1'b0;
      last_pol <= 1'b0;
    end else if (zero_cross) begin
      half_on <= h_conduct;
      if (h_conduct) begin
        last_pol <= line_pos;
        acc_h <= full ? 9'h000 : h_sum - {1'b0, h_mod};
      end else begin
        // Credit keeps accruing through a deferred half, so the next half of
        // the other polarity fires. Holding it would turn 50 percent into
        // one half in three.
        acc_h <= h_sum;
      end
    end
  end

  // Delayed burst: credit accrues p per line cycle and each on cycle spends
  // 100, so the on share follows demand. A burst may only follow another
  // directly or after at least the minimum run of off cycles.
  wire logic pos_zc = zero_cross && line_pos;
  wire logic [15:0] b_sum = acc_b + {9'h000, eff_sp};
  wire logic [15:0] b_need = {8'h00, min_cycles} * {9'h000, PCT_FULL};
  wire logic [15:0] b_used = (b_sum > {9'h000, PCT_FULL}) ?
                             b_sum - {9'h000, PCT_FULL} : 16'h0000;
  wire logic b_more = (burst_left != 8'h00);
  wire logic b_start = !b_more && (b_sum >= b_need) &&
                       (burst_on || off_cnt >= min_cycles);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_b <= 16'h0000;
      burst_left <= 8'h00;
      off_cnt <= RST_OFF_CNT;
      burst_on <= 1'b0;
      burst_first <= 1'b0;
    end else if (pos_zc) begin
      if (b_more || b_start) begin
        burst_on <= 1'b1;
        burst_first <= !burst_on;
        burst_left <= b_more ? burst_left - 8'h01 : min_cycles - 8'h01;
        acc_b <= b_used;
        off_cnt <= 8'h00;
      end else begin
        burst_on <= 1'b0;
        burst_first <= 1'b0;
        acc_b <= b_sum;
        off_cnt <= (off_cnt == 8'hff) ? off_cnt : off_cnt + 8'h01;
      end
    end else if (zero_cross) begin
      burst_first <= 1'b0;
    end
  end

  always_comb begin
    unique case (mode)
      AFG_BURST_DELAY: next_gate = burst_on && (!burst_first || fire_now);
      AFG_HALF: next_gate = half_on;
      AFG_PHASE, AFG_PHASE_RAMP: begin
        next_gate = full || (eff_sp != 7'h00 && fire_now);
      end
    endcase
  end

  // Read path answers in the next cycle; unmapped offsets read zero.
  wire logic [15:0] stat_word = {5'h00, hc_pos, valid, gate_out, 1'b0, eff_sp};
  wire logic [15:0] rd_mux =
    (reg_addr == OFF_CTRL) ? {13'h0000, src_op, mode} :
    (reg_addr == OFF_MIN_CYC) ? {8'h00, min_cycles} :
    (reg_addr == OFF_DELAY) ? {8'h00, delay_deg} :
    (reg_addr == OFF_RAMP) ? {8'h00, ramp_steps} :
    (reg_addr == OFF_SETPOINT) ? {9'h000, op_sp} :
    (reg_addr == OFF_AIN_GAIN) ? {8'h00, ain_gain} :
    (reg_addr == OFF_STATUS) ? stat_word :
    (reg_addr == OFF_PERIOD) ? period[19:4] : 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      gate_out <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      gate_out <= next_gate;
    end
  end

  delay_fire_a: assert property (
    (mode == AFG_BURST_DELAY && burst_on && burst_first && !fire_now)
    |=> !gate_out)
    else $error("burst output fired before the delay angle");

  burst_len_a: assert property (
    (pos_zc && !b_more && b_start) |=> (burst_left == min_cycles - 8'h01))
    else $error("burst did not load the minimum cycle count");

  half_balance_a: assert property (
    (zero_cross && !full && h_conduct) |-> (line_pos != last_pol))
    else $error("half cycle conducted with repeated polarity");

  full_on_a: assert property (
    (full && mode != AFG_BURST_DELAY && $stable(mode)) |=> gate_out)
    else $error("output not on at full demand");

  phase_off_a: assert property (
    (zero_cross && mode == AFG_PHASE && !full && $stable(eff_sp) &&
     thr != 20'h00000) |-> ##2 !gate_out)
    else $error("phase output did not end with the half cycle");

  phase_bypass_a: assert property (
    (mode == AFG_PHASE && !en_fall) |=> (eff_sp == $past(target)))
    else $error("plain phase mode did not bypass the ramp");

  enable_fall_a: assert property (
    (mode == AFG_PHASE_RAMP && en_fall) |=> (eff_sp == 7'h00) ##1 !gate_out)
    else $error("ramped phase output not cut when enable fell");

  ramp_rate_a: assert property (
    (mode != AFG_PHASE && ramp_steps != 8'h00 && !en_fall) |=>
    (eff_sp == $past(eff_sp) || eff_sp == $past(eff_sp) + 7'h01 ||
     eff_sp == $past(eff_sp) - 7'h01))
    else $error("effective set point jumped while ramping");

  enable_rise_a: assert property (
    (mode != AFG_PHASE && ramp_steps != 8'h00 && $rose(enable_in) &&
     eff_sp == 7'h00) |=> (eff_sp <= 7'h01))
    else $error("enable rise stepped instead of ramping");

  line_lost_a: assert property (
    (!valid && !full && (mode == AFG_PHASE || mode == AFG_PHASE_RAMP)) |=>
    !gate_out)
    else $error("phase output fired without a measured line period");

  period_meas_a: assert property (
    (zero_cross && timer != TIMER_MAX) |=>
    (timer == 20'h00000 && period == $past(timer) + 20'h00001))
    else $error("half cycle period not captured at the zero cross");

  half_hold_a: assert property (
    !zero_cross |=> $stable(half_on))
    else $error("half cycle decision changed between zero crosses");

  half_zero_a: assert property (
    (zero_cross && eff_sp == 7'h00) |=> !half_on)
    else $error("half cycle conducted at zero demand");

  burst_idle_a: assert property (
    (mode == AFG_BURST_DELAY && !burst_on) |=> !gate_out)
    else $error("burst output on outside a burst");

  ramp_tick_a: assert property (
    (mode != AFG_PHASE && ramp_steps != 8'h00 && !tick && !en_fall) |=>
    $stable(eff_sp))
    else $error("effective set point moved between ramp ticks");

  sp_range_a: assert property (
    eff_sp <= PCT_FULL)
    else $error("effective set point above full demand");

  mode_write_a: assert property (
    (reg_wr && reg_addr == OFF_CTRL) |=>
    (mode == $past(reg_wdata[CTRL_MODE_LSB +: 2])))
    else $error("firing type not taken from the control write");

endmodule

`default_nettype wire

// file: design/afg_pkg.sv
// Overview of operation
// - Delayed burst fires at the set delay angle after each burst's zero cross.
// - With two minimum cycles, bursts hold two on cycles, period scales with demand.
// - Burst on and off runs last at least minimum cycles; on share tracks demand.
// - Half-cycle mode decides on or off at every half line cycle.
// - Half-cycle mode balances positive and negative halves to avoid DC.
// - Half cycle: 25% one of three, 50% one of two, 66% two of three.
// - Phase angle conducts from turn-on point to the end of each half cycle.
// - Phase turn-on at 135, 90, 45 degrees for 25, 50, 75 percent.
// - At 100% demand every mode holds the output on continuously.
// - Plain phase-angle mode bypasses the soft-start ramp entirely.
// - Ramped phase angle moves set point gradually over ramp time in 50ms steps.
// - Enable rising ramps the effective set point from 0% to set point.
// - Ramped phase angle switches off at once when enable falls.
// - Soft start filters the set point in all modes except plain phase angle.
// - Soft start also applies when the enable input changes state, except a fall in ramped phase angle.
// - Firing selector offers delayed burst, half cycle, phase, ramped phase.
// - Set point comes from scaled analog input or operator value.
package afg_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int RAMP_STEP_MS = 50;
  localparam int RAMP_STEP_CYCLES = CLK_HZ / 1000 * RAMP_STEP_MS;
  // Cycles per one percent of movement for each ramp step.
  localparam int PCT_TICK_CYCLES = RAMP_STEP_CYCLES / 100;

  localparam int AW = 4;
  localparam int DW = 16;

  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_MIN_CYC = 4'h1;
  localparam logic [3:0] OFF_DELAY = 4'h2;
  localparam logic [3:0] OFF_RAMP = 4'h3;
  localparam logic [3:0] OFF_SETPOINT = 4'h4;
  localparam logic [3:0] OFF_AIN_GAIN = 4'h5;
  localparam logic [3:0] OFF_STATUS = 4'h6;
  localparam logic [3:0] OFF_PERIOD = 4'h7;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_BIT = 2;

  typedef enum logic [1:0] {
    AFG_BURST_DELAY = 2'h0,
    AFG_HALF = 2'h1,
    AFG_PHASE = 2'h2,
    AFG_PHASE_RAMP = 2'h3
  } afg_mode_t;

  localparam afg_mode_t RST_MODE = AFG_BURST_DELAY;
  localparam logic RST_SRC = 1'b1;
  localparam logic [7:0] RST_MIN_CYC = 8'h01;
  localparam logic [7:0] RST_DELAY = 8'h50;
  localparam logic [7:0] RST_RAMP = 8'h00;
  localparam logic [6:0] RST_SETPOINT = 7'h00;
  localparam logic [7:0] RST_AIN_GAIN = 8'h64;
  localparam logic [7:0] RST_OFF_CNT = 8'hff;

  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_HALF = 7'h32;
  localparam logic [7:0] DEG_MAX = 8'hb4;
  localparam logic [8:0] RECIP_180 = 9'h16c;
  localparam logic [8:0] PCT_TO_DEG = 9'h1cd;
  localparam logic [19:0] TIMER_MAX = 20'hfffff;

endpackage

// file: tb/afg_line_model.sv
`timescale 1ns/1ns
`default_nettype none

// Zero-cross detector: one pulse a half cycle, alternating polarity.
module afg_line_model #(
  parameter int HALF = 200
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic zero_cross,
  output logic line_pos
);
  int cnt;
  logic pol;
  wire logic hit = (cnt == HALF - 1);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      pol <= 1'b0;
      zero_cross <= 1'b0;
      line_pos <= 1'b0;
    end else begin
      cnt <= hit ? 0 : cnt + 1;
      zero_cross <= hit;
      // Polarity is only valid beside the pulse, so it toggles elsewhere.
      line_pos <= hit ? ~pol : ~line_pos;
      pol <= hit ? ~pol : pol;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import afg_pkg::*;
  localparam int HALF = 200;
  logic clk_sys, rst_n, reg_wr, reg_rd, enable_in, gate_out;
  logic zero_cross, line_pos;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rv;
  logic [11:0] ain_1;
  int err_count = 0, n_checks = 0, since_zc = 0, n, on, pos;

  afg_firing_gen #(.PCT_TICK(10)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zero_cross(zero_cross),
    .line_pos(line_pos), .enable_in(enable_in), .ain_1(ain_1),
    .gate_out(gate_out));
  afg_line_model #(.HALF(HALF)) line (.clk_sys(clk_sys), .rst_n(rst_n),
    .zero_cross(zero_cross), .line_pos(line_pos));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) since_zc <= zero_cross ? 0 : since_zc + 1;

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Angle scaling is approximate, so timing counts get a small slack.
  task automatic near(input int got, input int exp, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rv = reg_rdata;
  endtask

  task automatic sp_is(input int exp, input int tol);
    rd(OFF_STATUS);
    near($isunknown(rv[6:0]) ? -1 : int'(rv[6:0]), exp, tol);
  endtask

  task automatic halves(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      while (zero_cross !== 1'b1) @(posedge clk_sys);
    end
  endtask

  task automatic rise(output int r);
    while (gate_out !== 1'b0) @(posedge clk_sys);
    while (gate_out !== 1'b1) @(posedge clk_sys);
    r = since_zc;
  endtask

  task automatic count(input int k);
    on = 0;
    pos = 0;
    repeat (k) begin
      halves(1);
      n = int'(line_pos);
      repeat (HALF / 2) @(posedge clk_sys);
      on += int'(gate_out === 1'b1);
      pos += (gate_out === 1'b1) ? n : 0;
    end
  endtask

  task automatic t_regs();
    logic [DW-1:0] e [6] = '{16'h0004, 16'h0001, 16'h0050, 16'h0000,
      16'h0000, 16'h0064};
    for (int i = 0; i < 6; i++) begin
      rd(4'(i));
      chk(rv, e[i]);
    end
    rd(4'h8);
    chk(rv, 16'h0000);
    wr(OFF_SETPOINT, 16'h00c8);
    rd(OFF_SETPOINT);
    chk(rv, 16'h0064);
    wr(OFF_MIN_CYC, 16'h0000);
    rd(OFF_MIN_CYC);
    chk(rv, 16'h0001);
    wr(OFF_CTRL, 16'h0002);
    ain_1 <= 12'h800;
    repeat (4) @(posedge clk_sys);
    sp_is(50, 0);
    wr(OFF_AIN_GAIN, 16'h00c8);
    repeat (4) @(posedge clk_sys);
    sp_is(100, 0);
  endtask

  task automatic t_phase();
    wr(OFF_CTRL, 16'h0006);
    wr(OFF_RAMP, 16'h0005);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_SETPOINT, 16'(25 * (i + 1)));
      sp_is(25 * (i + 1), 0);
      halves(2);
      rise(n);
      near(n, HALF * (135 - 45 * i) / 180 + 1, 3);
      halves(1);
      chk({15'h0000, gate_out}, 16'h0001);
      repeat (3) @(posedge clk_sys);
      chk({15'h0000, gate_out}, 16'h0000);
    end
    wr(OFF_RAMP, 16'h0000);
  endtask

  task automatic t_full();
    wr(OFF_SETPOINT, 16'h0064);
    rd(OFF_PERIOD);
    chk(rv, 16'(HALF / 16));
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, 16'(4 + m));
      halves(6);
      rd(OFF_STATUS);
      chk(rv & 16'h03ff, 16'h0364);
      n = 0;
      repeat (2 * HALF) @(posedge clk_sys) n += int'(gate_out !== 1'b1);
      near(n, 0, 0);
    end
  endtask

  task automatic t_half();
    int s [3] = '{25, 50, 66};
    int e [3] = '{8, 12, 16};
    wr(OFF_CTRL, 16'h0005);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_SETPOINT, 16'(s[i]));
      halves(4);
      count(24);
      near(on, e[i], 2);
      near(2 * pos, on, 2);
    end
  endtask

  task automatic t_burst();
    int d [2] = '{50, 80};
    wr(OFF_CTRL, 16'h0004);
    wr(OFF_MIN_CYC, 16'h0002);
    wr(OFF_SETPOINT, 16'h0032);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_DELAY, 16'(d[i]));
      halves(8);
      count(32);
      near(on, 16, 4);
      rise(n);
      near(n, HALF * d[i] / 180 + 1, 3);
    end
  endtask

  task automatic t_ramp();
    wr(OFF_CTRL, 16'h0007);
    wr(OFF_RAMP, 16'h0001);
    enable_in <= 1'b0;
    wr(OFF_SETPOINT, 16'h003c);
    repeat (20) @(posedge clk_sys);
    sp_is(0, 0);
    enable_in <= 1'b1;
    repeat (200) @(posedge clk_sys);
    sp_is(20, 4);
    repeat (600) @(posedge clk_sys);
    sp_is(60, 0);
    wr(OFF_SETPOINT, 16'h0014);
    repeat (100) @(posedge clk_sys);
    sp_is(50, 4);
    repeat (500) @(posedge clk_sys);
    enable_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    sp_is(0, 0);
    n = 0;
    repeat (2 * HALF) @(posedge clk_sys) n += int'(gate_out === 1'b1);
    near(n, 0, 0);
    wr(OFF_CTRL, 16'h0005);
    enable_in <= 1'b1;
    repeat (100) @(posedge clk_sys);
    sp_is(10, 4);
  endtask

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    enable_in = 1'b1;
    ain_1 = 12'h000;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_phase();
    t_full();
    t_half();
    t_burst();
    t_ramp();
    test_done();
  end

  // The whole sequence needs roughly 45000 cycles.
  initial begin
    #800_000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
